// ===== logic/scrb_bank.sv
// system control register bank with wishbone slave and core control outputs
//
// Behaviour
// - aux fault status location reads zero and ignores every write.
// - fault status sub-registers are byte lanes of the combined fault word.
// - app irq/reset control reads 0xfa050000 after reset, 0xfa058000 with BIG_ENDIAN set; privileged only.
// - identity and config control resets fixed; config control resets 0x200.
// - critical read-under-write off holds ordered reads until stores complete.
// - add/sub allocation off forces all add/sub into second execute stage.
// - each channel1 issue off bit blocks one instruction type in channel 1.
// - each dual issue off bit stops dual issue for its type in channel 0.
// - read ordering bit holds ordered reads while any read is outstanding.
// - branch cache alloc off stops new entries; existing ones may update.
// - branch cache read off disables cache lookup; static prediction only.
// - trace flush off always reads 1, ignores writes, flush ready held high.
// - read allocate mode off disables dynamic read allocate mode.
// - float exception outputs off suppresses the float exception outputs.
// - identity register is read-only, implementer in 31:24; privileged only.
// - identity variant field 23:20 returns the major revision, 0 or 1.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "scrb_map.svh"

module scrb_bank #(
    parameter logic [7:0]  IMPLEMENTER = 8'h5a,  // arbitrary value
    parameter logic [3:0]  MAJOR_REV   = 4'h1,   // 0 or 1
    parameter logic [11:0] PART_NO     = 12'h123, // arbitrary value
    parameter logic [3:0]  MINOR_REV   = 4'h0,   // arbitrary value
    parameter logic        BIG_ENDIAN  = 1'b0    // data endianness strap
) (
    input  wire logic                        clk_i,      // 10 MHz clock
    input  wire logic                        rst_i,      // sync reset
    input  wire scrb_pkg::scrb_wb_req_s      wb_i,       // wishbone request
    input  wire logic                        priv_i,     // privileged access
    output var scrb_pkg::scrb_wb_rsp_s       wb_o,       // wishbone answer
    input  wire scrb_pkg::scrb_ar_req_s      ar_i,       // read issue request
    output logic                             ar_valid_o, // read may issue
    output logic                             ar_hold_o,  // read held back
    input  wire logic [`SCRB_FP_EXC_W-1:0]   fp_exc_i,   // float exceptions
    output logic [`SCRB_FP_EXC_W-1:0]       fp_exc_o,   // gated, registered
    output logic                             afready_o,  // trace flush ready
    output var scrb_pkg::scrb_core_ctl_s     core_ctl_o  // control to core
);
    import scrb_pkg::*;

    // ============================================================
    // state and decode
    scrb_state_s st;
    scrb_state_s next_st;
    logic [31:0] word_adr;
    logic [31:0] sel_mask;
    logic [31:0] rd_word;
    logic [31:0] aux_read;
    logic [31:0] cpu_identity_word;
    logic        commit;

    // classic wishbone decodes whole words; sub-registers use sel lanes
    assign word_adr = {wb_i.adr[31:2], 2'h0};
    assign commit   = (st.bus == BUS_ACK) && wb_i.cyc && wb_i.stb && wb_i.we;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign sel_mask[8*g+7:8*g] = {8{wb_i.sel[g]}};
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // implementer, variant, constant nibble, part, minor revision
    assign cpu_identity_word = {IMPLEMENTER, MAJOR_REV,
                                `SCRB_ID_CONST_VAL, PART_NO, MINOR_REV};

    always_comb
    begin
        aux_read = st.aux_control & `SCRB_AUX_WMASK;
        aux_read[`SCRB_AUX_TRACE_FLUSH] = 1'b1;
    end

    // ============================================================
    // read mux
    always_comb
    begin
        rd_word = `SCRB_RST_ZERO;
        case (word_adr)
            `SCRB_ADR_CPU_IDENTITY:
                rd_word = cpu_identity_word;
            `SCRB_ADR_AUX_CONTROL:
                rd_word = aux_read;
            `SCRB_ADR_IRQ_CONTROL_STATE:
            begin
                rd_word[`SCRB_ICS_NMI_SET]    = st.nmi_pend;
                rd_word[`SCRB_ICS_PENDSV_SET] = st.pendsv_pend;
                rd_word[`SCRB_ICS_PENDST_SET] = st.systick_pend;
            end
            `SCRB_ADR_VECTOR_TABLE_BASE:
                rd_word = st.vector_table_base;
            `SCRB_ADR_APP_IRQ_RESET_CONTROL:
            begin
                rd_word[`SCRB_AIRC_KEY]      = `SCRB_AIRC_READ_KEY;
                rd_word[`SCRB_AIRC_ENDIAN]   = BIG_ENDIAN;
                rd_word[`SCRB_AIRC_PRIGROUP] = st.prigroup;
            end
            `SCRB_ADR_SYSTEM_CONTROL:
                rd_word = st.system_control;
            `SCRB_ADR_CONFIG_CONTROL:
                rd_word = st.config_control;
            `SCRB_ADR_HANDLER_PRIORITY_1:
                rd_word = st.handler_priority[0];
            `SCRB_ADR_HANDLER_PRIORITY_2:
                rd_word = st.handler_priority[1];
            `SCRB_ADR_HANDLER_PRIORITY_3:
                rd_word = st.handler_priority[2];
            `SCRB_ADR_HANDLER_CONTROL_STATE:
                rd_word = st.handler_control_state;
            `SCRB_ADR_CONFIGURABLE_FAULT_STATUS:
                rd_word = st.configurable_fault_status;
            `SCRB_ADR_HARD_FAULT_STATUS:
                rd_word = st.hard_fault_status;
            `SCRB_ADR_MEMORY_MANAGE_FAULT_ADDR:
                rd_word = st.memory_manage_fault_addr;
            `SCRB_ADR_BUS_FAULT_ADDR:
                rd_word = st.bus_fault_addr;
            `SCRB_ADR_AUX_FAULT_STATUS:
                rd_word = `SCRB_RST_ZERO;
            default:
                rd_word = `SCRB_RST_ZERO;
        endcase
    end

    // ============================================================
    // next state
    always_comb
    begin
        next_st = st;
        next_st.sys_reset_req = 1'b0;
        // gating registered so the outputs come from flops
        next_st.fp_exc = fp_exc_i
            & ~{`SCRB_FP_EXC_W{st.aux_control[`SCRB_AUX_FP_EXC]}};
        unique case (st.bus)
            BUS_IDLE:
            begin
                if (wb_i.cyc && wb_i.stb)
                begin
                    // unprivileged software sees a bus error, nothing moves
                    if (!priv_i)
                        next_st.bus = BUS_ERR;
                    else
                    begin
                        next_st.bus   = BUS_ACK;
                        next_st.rdata = rd_word;
                    end
                end
            end
            BUS_ACK, BUS_ERR:
                next_st.bus = BUS_IDLE;
            default:
                next_st.bus = BUS_IDLE;
        endcase
        // writes land on the edge where the master samples ack
        if (commit)
        begin
            case (word_adr)
                `SCRB_ADR_AUX_CONTROL:
                    next_st.aux_control = merge(st.aux_control, wb_i.dat,
                        sel_mask & `SCRB_AUX_WMASK);
                `SCRB_ADR_IRQ_CONTROL_STATE:
                begin
                    if (wb_i.sel[3])
                    begin
                        // a set and clear together: set wins
                        if (wb_i.dat[`SCRB_ICS_PENDSV_CLR])
                            next_st.pendsv_pend = 1'b0;
                        if (wb_i.dat[`SCRB_ICS_PENDST_CLR])
                            next_st.systick_pend = 1'b0;
                        if (wb_i.dat[`SCRB_ICS_NMI_SET])
                            next_st.nmi_pend = 1'b1;
                        if (wb_i.dat[`SCRB_ICS_PENDSV_SET])
                            next_st.pendsv_pend = 1'b1;
                        if (wb_i.dat[`SCRB_ICS_PENDST_SET])
                            next_st.systick_pend = 1'b1;
                    end
                end
                `SCRB_ADR_VECTOR_TABLE_BASE:
                    next_st.vector_table_base = merge(st.vector_table_base,
                        wb_i.dat, sel_mask & `SCRB_VTB_MASK);
                `SCRB_ADR_APP_IRQ_RESET_CONTROL:
                begin
                    // key must be written whole, else the write is dropped
                    if (wb_i.sel[3] && wb_i.sel[2] &&
                        wb_i.dat[`SCRB_AIRC_KEY] == `SCRB_AIRC_WRITE_KEY)
                    begin
                        if (wb_i.sel[1])
                            next_st.prigroup = wb_i.dat[`SCRB_AIRC_PRIGROUP];
                        if (wb_i.sel[0])
                            next_st.sys_reset_req =
                                wb_i.dat[`SCRB_AIRC_SYSRESET];
                    end
                end
                `SCRB_ADR_SYSTEM_CONTROL:
                    next_st.system_control = merge(st.system_control,
                        wb_i.dat, sel_mask);
                `SCRB_ADR_CONFIG_CONTROL:
                    next_st.config_control = merge(st.config_control,
                        wb_i.dat, sel_mask);
                `SCRB_ADR_HANDLER_PRIORITY_1:
                    next_st.handler_priority[0] = merge(
                        st.handler_priority[0], wb_i.dat, sel_mask);
                `SCRB_ADR_HANDLER_PRIORITY_2:
                    next_st.handler_priority[1] = merge(
                        st.handler_priority[1], wb_i.dat, sel_mask);
                `SCRB_ADR_HANDLER_PRIORITY_3:
                    next_st.handler_priority[2] = merge(
                        st.handler_priority[2], wb_i.dat, sel_mask);
                `SCRB_ADR_HANDLER_CONTROL_STATE:
                    next_st.handler_control_state = merge(
                        st.handler_control_state, wb_i.dat, sel_mask);
                `SCRB_ADR_CONFIGURABLE_FAULT_STATUS:
                    next_st.configurable_fault_status = merge(
                        st.configurable_fault_status, wb_i.dat, sel_mask);
                `SCRB_ADR_HARD_FAULT_STATUS:
                    next_st.hard_fault_status = merge(
                        st.hard_fault_status, wb_i.dat, sel_mask);
                `SCRB_ADR_MEMORY_MANAGE_FAULT_ADDR:
                    next_st.memory_manage_fault_addr = merge(
                        st.memory_manage_fault_addr, wb_i.dat, sel_mask);
                `SCRB_ADR_BUS_FAULT_ADDR:
                    next_st.bus_fault_addr = merge(
                        st.bus_fault_addr, wb_i.dat, sel_mask);
                default:
                    next_st.bus = BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.aux_control    <= `SCRB_RST_AUX_CONTROL;
            st.config_control <= `SCRB_RST_CONFIG_CONTROL;
        end
        else
            st <= next_st;
    end

    // ============================================================
    // outputs
    assign wb_o.ack = (st.bus == BUS_ACK);
    assign wb_o.err = (st.bus == BUS_ERR);
    assign wb_o.dat = st.rdata;
    assign fp_exc_o = st.fp_exc;
    // flush never enabled: request ignored, ready held high
    assign afready_o = aux_read[`SCRB_AUX_TRACE_FLUSH];

    // ordered reads: device, strongly-ordered or exclusive-shareable
    assign ar_hold_o = ar_i.valid && ar_i.ordered &&
        ((st.aux_control[`SCRB_AUX_CRIT_RUW] &&
          ar_i.stores_outstanding) ||
         (st.aux_control[`SCRB_AUX_READ_ORDER] &&
          ar_i.reads_outstanding));
    assign ar_valid_o = ar_i.valid && !ar_hold_o;

    always_comb
    begin
        core_ctl_o.float_issue_option_off =
            st.aux_control[`SCRB_AUX_FLOAT_ISSUE];
        core_ctl_o.critical_read_under_write_off =
            st.aux_control[`SCRB_AUX_CRIT_RUW];
        core_ctl_o.addsub_allocation_off =
            st.aux_control[`SCRB_AUX_ADDSUB];
        core_ctl_o.channel1_issue_off = st.aux_control[`SCRB_AUX_CH1];
        core_ctl_o.dual_issue_off = st.aux_control[`SCRB_AUX_DUAL];
        core_ctl_o.read_ordering_on = st.aux_control[`SCRB_AUX_READ_ORDER];
        core_ctl_o.branch_cache_alloc_off =
            st.aux_control[`SCRB_AUX_BRANCH_TARGET_CACHE_ALLOC];
        core_ctl_o.branch_cache_read_off =
            st.aux_control[`SCRB_AUX_BRANCH_TARGET_CACHE_READ];
        core_ctl_o.trace_flush_off = aux_read[`SCRB_AUX_TRACE_FLUSH];
        core_ctl_o.read_allocate_mode_off =
            st.aux_control[`SCRB_AUX_RA_MODE];
        core_ctl_o.prigroup          = st.prigroup;
        core_ctl_o.vector_table_base = st.vector_table_base;
        core_ctl_o.sys_reset_req     = st.sys_reset_req;
        core_ctl_o.nmi_pend          = st.nmi_pend;
        core_ctl_o.pendsv_pend       = st.pendsv_pend;
        core_ctl_o.systick_pend      = st.systick_pend;
    end

    // ============================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_aux_fault_zero: assert property (
        wb_o.ack && word_adr == `SCRB_ADR_AUX_FAULT_STATUS |->
            wb_o.dat == `SCRB_RST_ZERO)
        else $error("aux fault status read not zero");

    chk_fault_byte_lane: assert property (
        commit && word_adr == `SCRB_ADR_CONFIGURABLE_FAULT_STATUS
            && wb_i.sel == 4'h2 |=>
            st.configurable_fault_status[15:8] == $past(wb_i.dat[15:8]) &&
            st.configurable_fault_status[31:16] ==
                $past(st.configurable_fault_status[31:16]) &&
            st.configurable_fault_status[7:0] ==
                $past(st.configurable_fault_status[7:0]))
        else $error("fault status lane write wrong");

    chk_airc_read_key: assert property (
        wb_o.ack && !wb_i.we &&
            word_adr == `SCRB_ADR_APP_IRQ_RESET_CONTROL |->
            wb_o.dat[`SCRB_AIRC_KEY] == `SCRB_AIRC_READ_KEY)
        else $error("app irq reset control key wrong");

    chk_unpriv_error: assert property (
        st.bus == BUS_IDLE && wb_i.cyc && wb_i.stb && !priv_i |=>
            wb_o.err && !wb_o.ack ##1 !wb_o.err)
        else $error("unprivileged access not refused");

    chk_config_reset: assert property (
        $fell(rst_i) |-> st.config_control == `SCRB_RST_CONFIG_CONTROL)
        else $error("config control reset value wrong");

    chk_read_hold: assert property (
        ar_i.valid && ar_i.ordered && ar_i.stores_outstanding &&
            core_ctl_o.critical_read_under_write_off |->
            !ar_valid_o && ar_hold_o)
        else $error("ordered read issued under store");

    chk_read_order: assert property (
        ar_i.valid && ar_i.ordered && ar_i.reads_outstanding &&
            core_ctl_o.read_ordering_on |-> !ar_valid_o)
        else $error("ordered read issued under read");

    chk_trace_flush: assert property (
        wb_o.ack && !wb_i.we && word_adr == `SCRB_ADR_AUX_CONTROL |->
            wb_o.dat[`SCRB_AUX_TRACE_FLUSH])
        else $error("trace flush off bit not one");

    chk_flush_ready: assert property (
        afready_o && core_ctl_o.trace_flush_off)
        else $error("flush ready not held high");

    chk_fp_exc_gate: assert property (
        st.aux_control[`SCRB_AUX_FP_EXC] |=> fp_exc_o == '0)
        else $error("float exceptions not suppressed");

    chk_identity_fields: assert property (
        wb_o.ack && !wb_i.we && word_adr == `SCRB_ADR_CPU_IDENTITY |->
            wb_o.dat[`SCRB_ID_VARIANT] == MAJOR_REV &&
            wb_o.dat[`SCRB_ID_IMPL] == IMPLEMENTER)
        else $error("identity fields wrong");

    chk_aux_reserved: assert property (
        wb_o.ack && !wb_i.we && word_adr == `SCRB_ADR_AUX_CONTROL |->
            (wb_o.dat & ~(`SCRB_AUX_WMASK | 32'h00001000)) == '0)
        else $error("reserved aux bits not zero");

    chk_write_ack: assert property (
        st.bus == BUS_IDLE && wb_i.cyc && wb_i.stb && wb_i.we && priv_i
            && word_adr == `SCRB_ADR_AUX_CONTROL ##1 wb_i.cyc |->
            ##1 core_ctl_o.branch_cache_alloc_off ==
                $past(wb_i.dat[`SCRB_AUX_BRANCH_TARGET_CACHE_ALLOC]))
        else $error("aux write not applied");

    cov_read: cover property (wb_o.ack && !wb_i.we);
    cov_key_write: cover property (commit &&
        word_adr == `SCRB_ADR_APP_IRQ_RESET_CONTROL);
    cov_error: cover property (wb_o.err);
    cov_hold: cover property (ar_hold_o);

endmodule // scrb_bank
`default_nettype wire

// ===== logic/scrb_map.svh
// address map, reset values and field positions of the register bank
`ifndef SCRB_MAP_SVH
`define SCRB_MAP_SVH

// ============================================================
// register byte addresses
`define SCRB_ADR_CPU_IDENTITY              32'he000e000
`define SCRB_ADR_AUX_CONTROL               32'he000e008
`define SCRB_ADR_IRQ_CONTROL_STATE         32'he000ed04
`define SCRB_ADR_VECTOR_TABLE_BASE         32'he000ed08
`define SCRB_ADR_APP_IRQ_RESET_CONTROL     32'he000ed0c
`define SCRB_ADR_SYSTEM_CONTROL            32'he000ed10
`define SCRB_ADR_CONFIG_CONTROL            32'he000ed14
`define SCRB_ADR_HANDLER_PRIORITY_1        32'he000ed18
`define SCRB_ADR_HANDLER_PRIORITY_2        32'he000ed1c
`define SCRB_ADR_HANDLER_PRIORITY_3        32'he000ed20
`define SCRB_ADR_HANDLER_CONTROL_STATE     32'he000ed24
`define SCRB_ADR_CONFIGURABLE_FAULT_STATUS 32'he000ed28
`define SCRB_ADR_MEMORY_MANAGE_FAULT_STATUS 32'he000ed28
`define SCRB_ADR_BUS_FAULT_STATUS          32'he000ed29
`define SCRB_ADR_USAGE_FAULT_STATUS        32'he000ed2a
`define SCRB_ADR_HARD_FAULT_STATUS         32'he000ed2c
`define SCRB_ADR_MEMORY_MANAGE_FAULT_ADDR  32'he000ed34
`define SCRB_ADR_BUS_FAULT_ADDR            32'he000ed38
`define SCRB_ADR_AUX_FAULT_STATUS          32'he000ed3c

// ============================================================
// reset values
`define SCRB_RST_ZERO           32'h00000000
`define SCRB_RST_AUX_CONTROL    32'h00000000
`define SCRB_RST_CONFIG_CONTROL 32'h00000200
`define SCRB_AIRC_READ_KEY      16'hfa05
`define SCRB_AIRC_WRITE_KEY     16'h05fa

// ============================================================
// aux_control fields
`define SCRB_AUX_FLOAT_ISSUE    28
`define SCRB_AUX_CRIT_RUW       27
`define SCRB_AUX_ADDSUB         26
`define SCRB_AUX_CH1            25:21
`define SCRB_AUX_DUAL           20:16
`define SCRB_AUX_READ_ORDER     15
`define SCRB_AUX_BRANCH_TARGET_CACHE_ALLOC     14
`define SCRB_AUX_BRANCH_TARGET_CACHE_READ      13
`define SCRB_AUX_TRACE_FLUSH    12
`define SCRB_AUX_RA_MODE        11
`define SCRB_AUX_FP_EXC         10
`define SCRB_AUX_WMASK          32'h1fffec00

// ============================================================
// other fields
`define SCRB_ID_IMPL            31:24
`define SCRB_ID_VARIANT         23:20
`define SCRB_ID_CONST_VAL       4'hf
`define SCRB_AIRC_KEY           31:16
`define SCRB_AIRC_ENDIAN        15
`define SCRB_AIRC_PRIGROUP      10:8
`define SCRB_AIRC_SYSRESET      2
`define SCRB_ICS_NMI_SET        31
`define SCRB_ICS_PENDSV_SET     28
`define SCRB_ICS_PENDSV_CLR     27
`define SCRB_ICS_PENDST_SET     26
`define SCRB_ICS_PENDST_CLR     25
`define SCRB_VTB_MASK           32'hffffff80
`define SCRB_FP_EXC_W           6

`endif

// ===== logic/scrb_pkg.sv
// types shared by the register bank and its users
`default_nettype none
`include "scrb_map.svh"
package scrb_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ACK  = 2'h1,
        BUS_ERR  = 2'h3
    } scrb_bus_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } scrb_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] dat;
    } scrb_wb_rsp_s;

    typedef struct packed {
        logic        valid;
        logic        ordered;
        logic        stores_outstanding;
        logic        reads_outstanding;
    } scrb_ar_req_s;

    typedef struct packed {
        logic        float_issue_option_off;
        logic        critical_read_under_write_off;
        logic        addsub_allocation_off;
        logic [4:0]  channel1_issue_off;
        logic [4:0]  dual_issue_off;
        logic        read_ordering_on;
        logic        branch_cache_alloc_off;
        logic        branch_cache_read_off;
        logic        trace_flush_off;
        logic        read_allocate_mode_off;
        logic [2:0]  prigroup;
        logic [31:0] vector_table_base;
        logic        sys_reset_req;
        logic        nmi_pend;
        logic        pendsv_pend;
        logic        systick_pend;
    } scrb_core_ctl_s;

    typedef struct packed {
        scrb_bus_e                 bus;
        logic [31:0]               rdata;
        logic [31:0]               aux_control;
        logic [31:0]               vector_table_base;
        logic [2:0]                prigroup;
        logic                      sys_reset_req;
        logic                      nmi_pend;
        logic                      pendsv_pend;
        logic                      systick_pend;
        logic [31:0]               system_control;
        logic [31:0]               config_control;
        logic [2:0][31:0]          handler_priority;
        logic [31:0]               handler_control_state;
        logic [31:0]               configurable_fault_status;
        logic [31:0]               hard_fault_status;
        logic [31:0]               memory_manage_fault_addr;
        logic [31:0]               bus_fault_addr;
        logic [`SCRB_FP_EXC_W-1:0] fp_exc;
    } scrb_state_s;

endpackage
`default_nettype wire

// ===== sim/scrb_bank_tb.sv
// self-checking bench for the system control register bank
`timescale 1ns/1ps
`default_nettype none
`include "scrb_map.svh"
module scrb_bank_tb;
    import scrb_pkg::*;
    localparam logic [7:0] IMPL = 8'h5a; // arbitrary value
    localparam logic [3:0] REV  = 4'h1;
    logic clk_i = 1'b0, rst_i = 1'b1, priv_i = 1'b1, e;
    scrb_wb_req_s wb_i = '0;
    scrb_wb_rsp_s wb_o;
    scrb_ar_req_s ar_i = '0;
    logic ar_valid_o, ar_hold_o, afready_o;
    logic [5:0] fp_exc_i = 6'h2a, fp_exc_o;
    scrb_core_ctl_s core_ctl_o;
    logic [31:0] r;
    logic [13:0] aux_bits;
    assign aux_bits = {core_ctl_o.addsub_allocation_off,
        core_ctl_o.channel1_issue_off, core_ctl_o.dual_issue_off,
        core_ctl_o.branch_cache_alloc_off, core_ctl_o.branch_cache_read_off,
        core_ctl_o.read_allocate_mode_off};
    int miscompares = 0, cmp_count = 0;
    always #50 clk_i = ~clk_i;
    scrb_bank #(.IMPLEMENTER(IMPL), .MAJOR_REV(REV)) scrb_bank_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .priv_i(priv_i),
        .wb_o(wb_o), .ar_i(ar_i), .ar_valid_o(ar_valid_o),
        .ar_hold_o(ar_hold_o), .fp_exc_i(fp_exc_i), .fp_exc_o(fp_exc_o),
        .afready_o(afready_o), .core_ctl_o(core_ctl_o));
    // ============================================================
    // shared tasks
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // holds the request until ack or err is sampled at an edge, giving up after 20 edges
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
        do @(posedge clk_i); while (!(wb_o.ack | wb_o.err) && ++n < 20);
        if (n >= 20) compare(32'h0, 32'h1);
        r = wb_o.dat;
        e = wb_o.err;
        wb_i <= '0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        compare(r, exp);
    endtask
    task automatic summarize();
        $display("mismatches %0d of %0d compares", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset();
        rd(`SCRB_ADR_AUX_CONTROL, 32'h00001000);
        compare({18'h0, aux_bits}, 32'h0);
        rd(`SCRB_ADR_CONFIG_CONTROL, 32'h00000200);
        rd(`SCRB_ADR_APP_IRQ_RESET_CONTROL, 32'hfa050000);
        bus(1'b0, `SCRB_ADR_CPU_IDENTITY, 32'h0, 4'hf);
        compare({24'h0, r[31:24]}, {24'h0, IMPL});
        compare({28'h0, r[23:20]}, {28'h0, REV});
        compare({31'h0, afready_o}, 32'h1);
    endtask
    task automatic t_regs();
        bus(1'b1, `SCRB_ADR_AUX_CONTROL, 32'hffffffff, 4'hf);
        rd(`SCRB_ADR_AUX_CONTROL, 32'h1ffffc00);
        compare({18'h0, aux_bits}, 32'h3fff);
        bus(1'b1, `SCRB_ADR_APP_IRQ_RESET_CONTROL, 32'h05fa0500, 4'hf);
        bus(1'b1, `SCRB_ADR_APP_IRQ_RESET_CONTROL, 32'h12340300, 4'hf);
        rd(`SCRB_ADR_APP_IRQ_RESET_CONTROL, 32'hfa050500);
        bus(1'b1, `SCRB_ADR_IRQ_CONTROL_STATE, 32'h94000000, 4'hf);
        bus(1'b1, `SCRB_ADR_IRQ_CONTROL_STATE, 32'h0a000000, 4'hf);
        rd(`SCRB_ADR_IRQ_CONTROL_STATE, 32'h80000000);
        bus(1'b1, `SCRB_ADR_AUX_FAULT_STATUS, 32'hffffffff, 4'hf);
        rd(`SCRB_ADR_AUX_FAULT_STATUS, 32'h0);
        bus(1'b1, `SCRB_ADR_BUS_FAULT_STATUS, 32'h5a5aab5a, 4'h2);
        rd(`SCRB_ADR_CONFIGURABLE_FAULT_STATUS, 32'h0000ab00);
        priv_i <= 1'b0;
        bus(1'b0, `SCRB_ADR_APP_IRQ_RESET_CONTROL, 32'h0, 4'hf);
        compare({31'h0, e}, 32'h1);
        priv_i <= 1'b1;
    endtask
    // read gate and float exception gating driven from aux_control
    task automatic t_gate(input logic [31:0] aux, input logic so,
                          input logic ro, input logic hold);
        bus(1'b1, `SCRB_ADR_AUX_CONTROL, aux, 4'hf);
        ar_i <= '{valid: 1'b1, ordered: 1'b1, stores_outstanding: so,
                  reads_outstanding: ro};
        repeat (2) @(posedge clk_i);
        compare({30'h0, ar_hold_o, ar_valid_o}, {30'h0, hold, !hold});
        compare({26'h0, fp_exc_o}, aux[10] ? 32'h0 : 32'h2a);
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_gate(32'h08000400, 1'b1, 1'b0, 1'b1);
        t_gate(32'h00008000, 1'b0, 1'b1, 1'b1);
        t_gate(32'h00000000, 1'b1, 1'b1, 1'b0);
        summarize();
    end
    initial
    begin
        #(100 * 400);
        miscompares++;
        summarize();
    end
endmodule // scrb_bank_tb
`default_nettype wire
